// *** src/timer_serial_irq_flags.sv ***
// interrupt factor flags and timer mode select behind a classic wishbone slave
`include "timer_flags_defines.svh"

module timer_serial_irq_flags
  import timer_flags_pkg::*;
#(
  parameter int ADDR_W = 16
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire flag_events_t events_i,
  output logic [7:0] flags_o,
  output logic wide_timer_select_o
);

  // elaboration check: offsets must fit the address bus
  if (ADDR_W < 16)
  begin : g_chk
    $error("ADDR_W must be at least 16");
  end

  // ----------------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------------
  logic [7:0] flags_q, flags_d;
  logic wide_q, wide_d;
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic req;
  logic hit_flags;
  logic hit_mode;
  logic wr_flags;
  logic wr_mode;
  logic rd_flags;
  logic rd_mode;
  logic [7:0] clr;
  logic [7:0] ev_bits;

  // ----------------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------------
  // true when the low 16 address bits name the register at the given offset
  function automatic logic reg_hit(input logic [15:0] adr, input logic [15:0] offset);
    reg_hit = (adr == offset);
  endfunction

  // a write only counts when it is taken and byte lane zero is selected
  function automatic logic lane0_write(input logic take, input logic wr, input logic [3:0] lanes,
                                       input logic hit);
    lane0_write = take && wr && lanes[0] && hit;
  endfunction

  // a read is taken whatever the lanes say; unused lanes read as zero
  function automatic logic reg_read(input logic take, input logic wr, input logic hit);
    reg_read = take && !wr && hit;
  endfunction

  // request accepted once; ack drops the cycle after it is given
  assign req = cyc_i && stb_i && !ack_q;
  assign hit_flags = reg_hit(adr_i[15:0], `FLAGS_OFFSET);
  assign hit_mode = reg_hit(adr_i[15:0], `MODE_OFFSET);
  // write and read strobes per register
  assign wr_flags = lane0_write(req, we_i, sel_i, hit_flags);
  assign wr_mode = lane0_write(req, we_i, sel_i, hit_mode);
  assign rd_flags = reg_read(req, we_i, hit_flags);
  assign rd_mode = reg_read(req, we_i, hit_mode);
  // ones written to the flag register clear, zeros leave the flag alone
  assign clr = wr_flags ? dat_i[7:0] : 8'h00;
  // source events as a plain vector, bit n sets flag bit n
  assign ev_bits = events_i;

  // ----------------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------------
  // flags: set wins over a write-one clear in the same cycle
  always_comb
  begin
    flags_d = (flags_q & ~clr) | ev_bits;
    wide_d = wide_q;
    if (wr_mode)
    begin
      wide_d = dat_i[`BIT_WIDE_SELECT];
    end
    ack_d = req;
    dat_d = 32'h0000_0000;
    if (rd_flags)
    begin
      dat_d = {24'h00_0000, flags_q};
    end
    else if (rd_mode)
    begin
      dat_d = {24'h00_0000, wide_q, 7'h00};
    end
  end

  // ----------------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------------
  // state and bus outputs, cleared by the synchronous reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flags_q <= `FLAGS_RESET;
      wide_q <= 1'(`MODE_RESET >> `BIT_WIDE_SELECT);
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end
    else
    begin
      flags_q <= flags_d;
      wide_q <= wide_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  // ----------------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------------
  // every output is a register
  assign flags_o = flags_q;
  assign wide_timer_select_o = wide_q;
  assign ack_o = ack_q;
  assign dat_o = dat_q;

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  // each source event sets its own flag, and nothing else sets one
  t8_flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    events_i.t8_underflow |=> flags_o[`BIT_T8_UNDERFLOW])
    else $error("t8 underflow flag not set");
  t8_flag_holds_a: assert property (@(posedge clk_i) disable iff (rst_i)
    flags_o[7] && !clr[7] |=> flags_o[7])
    else $error("t8 underflow flag lost");
  t16b_flags_a: assert property (@(posedge clk_i) disable iff (rst_i)
    events_i.t16b_compare |=> flags_o[`BIT_T16B_COMPARE])
    else $error("timer one compare flag not set");
  t16b_under_a: assert property (@(posedge clk_i) disable iff (rst_i)
    events_i.t16b_underflow |=> flags_o[`BIT_T16B_UNDERFLOW])
    else $error("timer one underflow flag not set");
  t16a_flags_a: assert property (@(posedge clk_i) disable iff (rst_i)
    events_i.t16a_compare |=> flags_o[`BIT_T16A_COMPARE])
    else $error("timer zero compare flag not set");
  t16a_under_a: assert property (@(posedge clk_i) disable iff (rst_i)
    events_i.t16a_underflow |=> flags_o[`BIT_T16A_UNDERFLOW])
    else $error("timer zero underflow flag not set");
  tx_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    events_i.serial_tx_done |=> flags_o[`BIT_TX_DONE])
    else $error("tx done flag not set");
  rx_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    events_i.serial_rx_done |=> flags_o[`BIT_RX_DONE])
    else $error("rx done flag not set");
  err_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    events_i.serial_rx_error |=> flags_o[`BIT_RX_ERROR])
    else $error("rx error flag not set");
  no_stray_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (flags_o & ~$past(flags_o) & ~$past(ev_bits)) == 8'h00)
    else $error("flag set without its source event");
  pending_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (flags_o & ~clr) != 8'h00 |=> (flags_o & $past(flags_o & ~clr)) == $past(flags_o & ~clr))
    else $error("pending flag lost without a clear");
  set_wins_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ev_bits != 8'h00 |=> (flags_o & $past(ev_bits)) == $past(ev_bits))
    else $error("clear beat a source event");

  // ----------------------------------------------------------------------------
  // assertions: clearing, reset, mode select and flag reads
  // ----------------------------------------------------------------------------
  // write-one clear, zero writes keep, reset values, mode bit access, flag read data
  w1c_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    clr[0] && !events_i.serial_rx_error |=> !flags_o[0])
    else $error("write one did not clear flag");
  w1c_all_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (clr & ~ev_bits) != 8'h00 |=> (flags_o & $past(clr & ~ev_bits)) == 8'h00)
    else $error("write one left a flag set");
  zero_write_keeps_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_flags && dat_i[7:0] == 8'h00 |=> flags_o == ($past(flags_o) | $past(ev_bits)))
    else $error("zero write changed a flag");
  reset_values_a: assert property (@(posedge clk_i)
    rst_i |=> flags_o == 8'h00 && !wide_timer_select_o && !ack_o)
    else $error("reset did not clear flags, mode or ack");
  mode_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_mode |=> wide_timer_select_o == $past(dat_i[`BIT_WIDE_SELECT]))
    else $error("mode select not written");
  mode_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !wr_mode |=> $stable(wide_timer_select_o))
    else $error("mode select changed without a write");
  mode_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_mode |=> dat_o == {24'h00_0000, $past(wide_timer_select_o), 7'h00})
    else $error("mode read data wrong");
  flags_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_flags |=> dat_o == {24'h00_0000, $past(flags_o)})
    else $error("flag read data wrong");

  // ----------------------------------------------------------------------------
  // assertions: bus handshake and read data
  // ----------------------------------------------------------------------------
  // one ack per taken request, data only after a mapped read
  ack_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req |=> ack_o)
    else $error("request not acknowledged");
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  ack_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !req |=> !ack_o)
    else $error("ack without a request");
  unmapped_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !we_i && !hit_flags && !hit_mode |=> dat_o == 32'h0000_0000)
    else $error("unmapped read returned data");
  dat_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !rd_flags && !rd_mode |=> dat_o == 32'h0000_0000)
    else $error("read data without a read");
  upper_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    dat_o[31:8] == 24'h00_0000)
    else $error("upper read data bits not zero");

endmodule

// *** src/timer_flags_defines.svh ***
// register offsets, field positions and reset values for the timer/serial flag block
// Behaviour
// - an 8-bit timer underflow sets flag bit 7, which reads one until software clears it.
// - a timer one compare match sets bit 6 and a timer one underflow sets bit 5, each reading one while pending.
// - a timer zero compare match sets bit 4 and a timer zero underflow sets bit 3, each reading one while pending.
// - a completed serial transmission sets bit 2.
// - a completed serial reception sets bit 1.
// - a serial receive error sets bit 0.
// - bit 7 of the mode register selects one 16-bit timer when one and two 8-bit timers when zero, resets to zero and is read/write.
`ifndef TIMER_FLAGS_DEFINES_SVH
`define TIMER_FLAGS_DEFINES_SVH

// ----------------------------------------------------------------------------
// offsets and fields
// ----------------------------------------------------------------------------
`define FLAGS_OFFSET 16'hff28
`define MODE_OFFSET 16'hff30
`define FLAGS_RESET 8'h00
`define MODE_RESET 8'h00
`define BIT_T8_UNDERFLOW 7
`define BIT_T16B_COMPARE 6
`define BIT_T16B_UNDERFLOW 5
`define BIT_T16A_COMPARE 4
`define BIT_T16A_UNDERFLOW 3
`define BIT_TX_DONE 2
`define BIT_RX_DONE 1
`define BIT_RX_ERROR 0
`define BIT_WIDE_SELECT 7

`endif

// *** src/timer_flags_pkg.sv ***
// types shared by the timer/serial flag block
package timer_flags_pkg;

  // one-cycle source events, bit order equals flag register order
  typedef struct packed {
    logic t8_underflow;
    logic t16b_compare;
    logic t16b_underflow;
    logic t16a_compare;
    logic t16a_underflow;
    logic serial_tx_done;
    logic serial_rx_done;
    logic serial_rx_error;
  } flag_events_t;

endpackage

// *** verification/tb_top.sv ***
// bus-level testbench for the timer/serial flag block
`include "timer_flags_defines.svh"
module tb_top import timer_flags_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, wide;
  logic [15:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] dat = 0, dat_o;
  logic ack_o;
  logic [7:0] flags_o, r, e;
  flag_events_t ev = '0;
  int error_cnt = 0, cmp_count = 0, cyc_cnt = 0;
  // ----------------------------------------
  // clock, device, timeout
  // ----------------------------------------
  always #5 clk_i = ~clk_i;
  timer_serial_irq_flags dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
    .events_i(ev), .flags_o(flags_o), .wide_timer_select_o(wide));
  always @(posedge clk_i)
  begin
    cyc_cnt++;
    if (cyc_cnt == 5000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  // one wishbone cycle; the event pulse lands on the taking edge
  task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] d,
                    input logic [7:0] x, output logic [7:0] q);
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; sel <= 4'hf; dat <= {24'h00_0000, d};
    ev <= flag_events_t'(x);
    @(posedge clk_i);
    ev <= '0;
    // wait for the answer; only the bench timeout ends a hang
    while (ack_o !== 1'b1)
    begin
      @(posedge clk_i);
    end
    q = dat_o[7:0];
    cyc <= 0; stb <= 0;
  endtask
  task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] s);
    cmp_count++;
    if (s !== x)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, x, s);
      error_cnt++;
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    wb(0, `FLAGS_OFFSET, 8'h00, 8'h00, r); chk("flags reset", 8'h00, r);
    wb(0, `MODE_OFFSET, 8'h00, 8'h00, r); chk("mode reset", 8'h00, r);
    // each source sets its own bit; zero writes leave earlier flags
    e = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      e = e | (8'h01 << i);
      wb(1, `FLAGS_OFFSET, 8'h00, 8'h01 << i, r);
      wb(0, `FLAGS_OFFSET, 8'h00, 8'h00, r); chk("flags set", e, r);
      chk("flags pin", e, flags_o);
    end
    wb(1, `FLAGS_OFFSET, 8'h0f, 8'h00, r);
    wb(0, `FLAGS_OFFSET, 8'h00, 8'h00, r); chk("partial clear", 8'hf0, r);
    wb(1, `FLAGS_OFFSET, 8'hf0, 8'h80, r);
    wb(0, `FLAGS_OFFSET, 8'h00, 8'h00, r); chk("set over clear", 8'h80, r);
    wb(1, `MODE_OFFSET, 8'h80, 8'h00, r);
    wb(0, `MODE_OFFSET, 8'h00, 8'h00, r); chk("mode wide", 8'h80, r);
    chk("wide pin", 8'h01, {7'h00, wide});
    wb(1, `MODE_OFFSET, 8'h00, 8'h00, r);
    wb(0, `MODE_OFFSET, 8'h00, 8'h00, r); chk("mode dual", 8'h00, r);
    wb(0, 16'h0000, 8'h00, 8'h00, r); chk("unmapped", 8'h00, r);
    // a second reset in mid-run clears the pending flag and the mode bit
    wb(1, `MODE_OFFSET, 8'h80, 8'h00, r);
    @(posedge clk_i);
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    wb(0, `FLAGS_OFFSET, 8'h00, 8'h00, r); chk("flags after reset", 8'h00, r);
    wb(0, `MODE_OFFSET, 8'h00, 8'h00, r); chk("mode after reset", 8'h00, r);
    chk("wide pin after reset", 8'h00, {7'h00, wide});
    tally_and_finish();
  end
endmodule
